// *** lec_link_counters.sv ***
// link error counters: per-tributary data link counters and station counters
// assumes event strobes come from logic on core_clk_i; one event per cycle
// point-to-point mode keeps only slot zero live; clears still follow the read select
`timescale 1ns/1ps
module lec_link_counters
	import lec_pkg::*;
#(
	parameter int NUM_TRIB = `LEC_NUM_TRIB,
	parameter int NUM_STN  = 4
) (
	input  wire logic                        core_clk_i,
	input  wire logic                        rst_n_i,
	input  wire logic                        multipoint_i,
	input  wire logic [$clog2(NUM_TRIB)-1:0] trib_sel_i,
	input  wire lec_event_type               event_i,
	input  wire logic [2:0]                  bkg_inc_i,
	input  wire logic [NUM_STN-1:0]          stn_inc_i,
	input  wire logic [3:0]                  stn_flag_set_i,
	input  wire logic                        establish_i,
	input  wire logic                        trib_rd_clr_i,
	input  wire logic                        glob_rd_clr_i,
	input  wire logic [$clog2(NUM_TRIB)-1:0] rd_trib_i,
	input  wire logic [2:0]                  rd_group_i,
	output lec_cum_type                      rd_cum_o,
	output logic      [`LEC_BKG_W-1:0]       rd_bkg_tx_o,
	output logic      [`LEC_BKG_W-1:0]       rd_bkg_rx_o,
	output logic      [`LEC_BKG_W-1:0]       rd_bkg_sel_o,
	output logic      [`LEC_CUM_W*NUM_STN-1:0] stn_count_o,
	output logic      [3:0]                  stn_flags_o,
	output logic                             out_header_check_flag_o,
	output logic                             out_datafield_check_flag_o,
	output logic                             out_reply_response_flag_o
);
	localparam int TW = $clog2(NUM_TRIB);
	localparam int NG = int'(`LEC_NUM_CUM);
	localparam int NB = int'(`LEC_NUM_BKG);

	initial begin
		if (NUM_TRIB < 2 || NUM_STN < 1) begin
			$error("lec_link_counters: need two tributaries and one station counter");
		end
		// the group and background increment ports are three bits wide
		if (NG > 8 || NB > 3) begin
			$error("lec_link_counters: group or background count exceeds its port");
		end
		if ($bits(rd_cum_o.count) != `LEC_CUM_W) begin
			$error("lec_link_counters: group count field disagrees with counter width");
		end
	end

	// tributary status slots in data memory
	lec_cum_type              tributary_status_slot_q [NUM_TRIB][NG];
	logic [`LEC_BKG_W-1:0]    bkg_q [NUM_TRIB][NB];

	// point-to-point folds every event onto slot zero
	logic [TW-1:0] act_trib;
	assign act_trib = multipoint_i ? trib_sel_i : '0;

	function automatic logic [3:0] reason_flag(input logic [4:0] rsn);
		unique case (rsn)
			`LEC_RSN_HDR:    reason_flag = 4'h1;
			`LEC_RSN_DATA:   reason_flag = 4'h2;
			`LEC_RSN_REP:    reason_flag = 4'h4;
			// buffer reasons reuse bits zero and one within the buffer groups
			`LEC_RSN_BUF_TU: reason_flag = 4'h1;
			`LEC_RSN_BUF_TS: reason_flag = 4'h2;
			default:         reason_flag = 4'h0;
		endcase
	endfunction

	function automatic logic [7:0] sat8(input logic [7:0] v);
		sat8 = (v == `LEC_CUM_MAX) ? v : v + 8'h01;
	endfunction

	// slot clear: establish or read-and-clear of the chosen tributary
	logic clr_slot;
	assign clr_slot = establish_i || trib_rd_clr_i;

	function automatic logic trib_match(input logic [TW-1:0] sel, input int idx);
		trib_match = (sel == TW'(idx));
	endfunction

	// per-slot strobes decoded once and shared by counters and flags
	logic [NUM_TRIB-1:0] clr_hit;
	logic [NUM_TRIB-1:0] inc_hit;
	genvar h;
	generate
		for (h = 0; h < NUM_TRIB; h++) begin : g_hit
			assign clr_hit[h] = clr_slot && trib_match(rd_trib_i, h);
			assign inc_hit[h] = trib_match(act_trib, h);
		end
	endgenerate

	// one-hot group strobe of the current event
	logic [NG-1:0] grp_hit;
	genvar q;
	generate
		for (q = 0; q < NG; q++) begin : g_grp
			assign grp_hit[q] = event_i.valid && (event_i.group == 3'(q));
		end
	endgenerate

	logic [3:0] ev_flags;
	always_comb begin
		ev_flags = event_i.flag_set;
		// negative acknowledgements carry the type in their reason code
		if (event_i.nak_rx) begin
			ev_flags = ev_flags | reason_flag(event_i.reason);
		end
	end

	always_ff @(posedge core_clk_i) begin
		for (int t = 0; t < NUM_TRIB; t++) begin
			for (int g = 0; g < NG; g++) begin
				if (!rst_n_i) begin
					tributary_status_slot_q[t][g] <= '0;
				end else if (clr_hit[t]) begin
					// clear beats a same-cycle event; read the counts first
					tributary_status_slot_q[t][g] <= '0;
				end else if (inc_hit[t] && grp_hit[g]) begin
					tributary_status_slot_q[t][g].count <=
						sat8(tributary_status_slot_q[t][g].count);
					tributary_status_slot_q[t][g].flags <=
						tributary_status_slot_q[t][g].flags | ev_flags;
				end
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		for (int t = 0; t < NUM_TRIB; t++) begin
			for (int b = 0; b < NB; b++) begin
				if (!rst_n_i) begin
					bkg_q[t][b] <= '0;
				end else if (clr_hit[t]) begin
					bkg_q[t][b] <= '0;
				end else if (bkg_inc_i[b] && inc_hit[t]
						&& bkg_q[t][b] != `LEC_BKG_MAX) begin
					bkg_q[t][b] <= bkg_q[t][b] + 16'h0001;
				end
			end
		end
	end

	// selects past the last slot read as zero rather than an undefined word
	logic rd_in_range;
	logic rd_grp_ok;
	assign rd_in_range = int'(rd_trib_i) < NUM_TRIB;
	assign rd_grp_ok   = int'(rd_group_i) < NG;

	// registered read port; read-and-clear returns the old value
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || !rd_in_range) begin
			rd_cum_o     <= '0;
			rd_bkg_tx_o  <= '0;
			rd_bkg_rx_o  <= '0;
			rd_bkg_sel_o <= '0;
		end else begin
			rd_cum_o     <= rd_grp_ok ?
				tributary_status_slot_q[rd_trib_i][rd_group_i] : '0;
			rd_bkg_tx_o  <= bkg_q[rd_trib_i][LEC_B_TX];
			rd_bkg_rx_o  <= bkg_q[rd_trib_i][LEC_B_RX];
			rd_bkg_sel_o <= bkg_q[rd_trib_i][LEC_B_SEL];
		end
	end

	lec_cum_type out_slot;
	assign out_slot = tributary_status_slot_q[rd_trib_i][LEC_G_OUT_DATA];

	// outbound flags of the tributary being read
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || !rd_in_range) begin
			out_header_check_flag_o    <= 1'b0;
			out_datafield_check_flag_o <= 1'b0;
			out_reply_response_flag_o  <= 1'b0;
		end else begin
			out_header_check_flag_o    <= out_slot.flags[`LEC_FLG_HDR];
			out_datafield_check_flag_o <= out_slot.flags[`LEC_FLG_DATA];
			out_reply_response_flag_o  <= out_slot.flags[`LEC_FLG_REP];
		end
	end

	// global status slots: one station set for the whole line
	genvar s;
	generate
		for (s = 0; s < NUM_STN; s++) begin : g_stn
			lec_sat_cnt #(
				.WIDTH (`LEC_CUM_W)
			) u_stn (
				.core_clk_i (core_clk_i),
				.rst_n_i    (rst_n_i),
				.clr_i      (glob_rd_clr_i),
				.inc_i      (stn_inc_i[s]),
				.count_o    (stn_count_o[s*`LEC_CUM_W +: `LEC_CUM_W])
			);
		end
	endgenerate

	always_ff @(posedge core_clk_i) begin
		// clear wins over a same-cycle set, as in the slots
		if (!rst_n_i || glob_rd_clr_i) begin
			stn_flags_o <= '0;
		end else begin
			stn_flags_o <= stn_flags_o | stn_flag_set_i;
		end
	end
endmodule

// *** lec_consts.svh ***
// constants for the link error counter block
// assumes inclusion by the package and by design modules
`ifndef LEC_CONSTS_SVH
`define LEC_CONSTS_SVH
`define LEC_CUM_W        8
`define LEC_BKG_W        16
`define LEC_CUM_MAX      8'hff
`define LEC_BKG_MAX      16'hffff
`define LEC_NUM_CUM      3'h7
`define LEC_NUM_BKG      2'h3
`define LEC_RSN_HDR      5'h01
`define LEC_RSN_DATA     5'h02
`define LEC_RSN_REP      5'h03
`define LEC_RSN_BUF_TU   5'h08
`define LEC_RSN_BUF_TS   5'h10
`define LEC_FLG_HDR      0
`define LEC_FLG_DATA     1
`define LEC_FLG_REP      2
`define LEC_NUM_TRIB     12
`endif

// *** lec_pkg.sv ***
// types shared by the link error counter block
// assumes lec_consts.svh is on the include path
`include "lec_consts.svh"
package lec_pkg;
	typedef enum logic [2:0] {
		LEC_G_OUT_DATA   = 3'h0,
		LEC_G_IN_DATA    = 3'h1,
		LEC_G_LOC_REPTO  = 3'h2,
		LEC_G_REM_REPTO  = 3'h3,
		LEC_G_LOC_BUF    = 3'h4,
		LEC_G_REM_BUF    = 3'h5,
		LEC_G_SEL_TO     = 3'h6
	} lec_group_type;

	typedef enum logic [1:0] {
		LEC_B_TX   = 2'h0,
		LEC_B_RX   = 2'h1,
		LEC_B_SEL  = 2'h2
	} lec_bkg_type;

	// one cumulative group: counter plus its type flags
	typedef struct packed {
		logic [7:0] count;
		logic [3:0] flags;
	} lec_cum_type;

	// one event as presented by the link controller
	typedef struct packed {
		logic       valid;
		logic       nak_rx;
		logic [4:0] reason;
		logic [2:0] group;
		logic [3:0] flag_set;
	} lec_event_type;
endpackage

// *** lec_sat_cnt.sv ***
// saturating counter with synchronous clear
// assumes one clock, clear has priority over increment
`timescale 1ns/1ps
module lec_sat_cnt #(
	parameter int WIDTH = 8
) (
	input  wire logic             core_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             clr_i,
	input  wire logic             inc_i,
	output logic      [WIDTH-1:0] count_o
);
	initial begin
		if (WIDTH < 1) begin
			$error("lec_sat_cnt: width must be at least one");
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || clr_i) begin
			count_o <= '0;
		end else if (inc_i && !(&count_o)) begin
			count_o <= count_o + 1'b1;
		end
	end
endmodule

// *** lec_far_station.sv ***
// remote station model: answers each request with a negative acknowledgement
// assumes one-cycle send_i pulses; DLY sets a prompt or slow answer
`timescale 1ns/1ps
module lec_far_station
	import lec_pkg::*;
#(
	parameter int DLY = 3
) (
	input  wire logic       core_clk_i,
	input  wire logic       send_i,
	input  wire logic [4:0] reason_i,
	output lec_event_type   nak_o
);
	int         cnt = 0;
	logic [4:0] rsn_q = '0;
	initial nak_o = '0;
	always @(posedge core_clk_i) begin
		nak_o.valid <= 1'b0;
		// idle code keeps changing so a stale reason is never mistaken
		nak_o.reason <= ~nak_o.reason;
		if (cnt > 0)
			cnt <= cnt - 1;
		if (cnt == 1)
			nak_o <= '{1'b1, 1'b1, rsn_q, 3'h0, 4'h0};
		if (send_i) begin
			cnt <= DLY;
			rsn_q <= reason_i;
		end
	end
endmodule

// *** lec_link_counters_assertions.sv ***
// checker for the link error counters
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
module lec_link_counters_assertions
	import lec_pkg::*;
#(
	parameter int NUM_TRIB = 12,
	parameter int NUM_STN  = 4
) (
	input wire logic                        core_clk_i,
	input wire logic                        rst_n_i,
	input wire logic                        multipoint_i,
	input wire logic [$clog2(NUM_TRIB)-1:0] trib_sel_i,
	input wire lec_event_type               event_i,
	input wire logic [NUM_STN-1:0]          stn_inc_i,
	input wire logic                        establish_i,
	input wire logic                        trib_rd_clr_i,
	input wire logic                        glob_rd_clr_i,
	input wire logic [$clog2(NUM_TRIB)-1:0] rd_trib_i,
	input wire logic [2:0]                  rd_group_i,
	input wire lec_cum_type                 rd_cum_o,
	input wire logic [8*NUM_STN-1:0]        stn_count_o,
	input wire logic [3:0]                  stn_flags_o,
	input wire logic                        out_header_check_flag_o,
	input wire logic                        out_datafield_check_flag_o,
	input wire logic                        out_reply_response_flag_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// no clear in either cycle; a clear with the event wins and the flag stays low
	property p_flag(logic [4:0] r, logic f);
		multipoint_i && event_i.valid && event_i.nak_rx && event_i.reason == r
			&& event_i.group == 3'h0 && trib_sel_i == rd_trib_i && !trib_rd_clr_i
			&& !establish_i ##1 $stable(rd_trib_i) && !trib_rd_clr_i && !establish_i |=> f;
	endproperty
	AST_HDR_FLAG: assert property (p_flag(5'h01, out_header_check_flag_o))
		else $error("header check flag missing");
	AST_DATA_FLAG: assert property (p_flag(5'h02, out_datafield_check_flag_o))
		else $error("data-field check flag missing");
	AST_REP_FLAG: assert property (p_flag(5'h03, out_reply_response_flag_o))
		else $error("reply response flag missing");
	AST_STN_INC: assert property (stn_inc_i[0] && stn_count_o[7:0] != 8'hff && !glob_rd_clr_i
		|=> stn_count_o[7:0] == $past(stn_count_o[7:0]) + 8'h01)
		else $error("station count did not step");
	AST_STN_SAT: assert property (stn_count_o[15:8] == 8'hff && !glob_rd_clr_i
		|=> stn_count_o[15:8] == 8'hff)
		else $error("station count left saturation");
	AST_STN_CLR: assert property (glob_rd_clr_i |=> stn_count_o == '0 && stn_flags_o == 4'h0)
		else $error("station counters not cleared");
	AST_STN_FLAGS: assert property (!glob_rd_clr_i
		|=> (stn_flags_o & $past(stn_flags_o)) == $past(stn_flags_o))
		else $error("station flag dropped");
	AST_RST: assert property (disable iff (1'b0) !rst_n_i
		|=> stn_count_o == '0 && rd_cum_o == '0 && stn_flags_o == 4'h0)
		else $error("counters not zero after reset");
	AST_TRIB_CLR: assert property (trib_rd_clr_i ##1 $stable(rd_trib_i) && $stable(rd_group_i)
		&& !event_i.valid |=> rd_cum_o == '0)
		else $error("tributary set not cleared");
	cover property (event_i.valid && event_i.nak_rx);
	cover property (stn_count_o[7:0] == 8'hff);
	cover property (trib_rd_clr_i);
endmodule
bind lec_link_counters lec_link_counters_assertions #(.NUM_TRIB(NUM_TRIB), .NUM_STN(NUM_STN))
	u_chk (.core_clk_i, .rst_n_i, .multipoint_i, .trib_sel_i, .event_i, .stn_inc_i, .establish_i,
	.trib_rd_clr_i, .glob_rd_clr_i, .rd_trib_i, .rd_group_i, .rd_cum_o, .stn_count_o,
	.stn_flags_o, .out_header_check_flag_o, .out_datafield_check_flag_o,
	.out_reply_response_flag_o);

// *** lec_link_counters_tb_top.sv ***
// self-checking bench for the link error counters
// assumes default NUM_TRIB and NUM_STN; remote answers come from lec_far_station
`timescale 1ns/1ps
module lec_link_counters_tb_top;
	import lec_pkg::*;
	logic          clk, rst_n, mp, send, est, tclr, gclr, fh, fd, fr;
	logic [3:0]    tsel, rtrib, sfl, sinc, sfo;
	logic [2:0]    rgrp, bkg;
	logic [4:0]    rsn;
	logic [15:0]   btx, brx, bsel;
	logic [31:0]   scnt;
	lec_event_type tev, nk, ev;
	lec_cum_type   cum;
	int            errors = 0, checked = 0;
	assign ev = nk.valid ? nk : tev;
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	lec_link_counters u_dut (.core_clk_i(clk), .rst_n_i(rst_n), .multipoint_i(mp),
		.trib_sel_i(tsel), .event_i(ev), .bkg_inc_i(bkg), .stn_inc_i(sinc), .stn_flag_set_i(sfl),
		.establish_i(est), .trib_rd_clr_i(tclr), .glob_rd_clr_i(gclr), .rd_trib_i(rtrib),
		.rd_group_i(rgrp), .rd_cum_o(cum), .rd_bkg_tx_o(btx), .rd_bkg_rx_o(brx),
		.rd_bkg_sel_o(bsel), .stn_count_o(scnt), .stn_flags_o(sfo), .out_header_check_flag_o(fh),
		.out_datafield_check_flag_o(fd), .out_reply_response_flag_o(fr));
	lec_far_station #(.DLY(5)) u_far (.core_clk_i(clk), .send_i(send), .reason_i(rsn), .nak_o(nk));
	task summarize;
		if (errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(string n, logic [31:0] e, logic [31:0] g);
		checked++;
		if (e !== g) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task evt(logic [2:0] g);
		@(posedge clk) tev <= '{1'b1, 1'b0, 5'h0, g, 4'h0};
		@(posedge clk) tev.valid <= 1'b0;
	endtask
	task nak(logic [4:0] r);
		@(posedge clk) begin
			send <= 1'b1;
			rsn <= r;
		end
		@(posedge clk) send <= 1'b0;
		for (int i = 0; i < 20 && nk.valid !== 1'b1; i++) tick(1);
		if (nk.valid !== 1'b1) begin
			errors++;
			summarize();
		end
		tick(1);
	endtask
	task rd(logic [3:0] t, logic [2:0] g);
		@(posedge clk) begin
			rtrib <= t;
			rgrp <= g;
		end
		tick(2);
	endtask
	initial begin
		{rst_n, mp, send, est, tclr, gclr, tsel, rtrib, sfl, sinc, rgrp, bkg, rsn} = '0;
		tev = '0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(4'h3, 3'h0);
		chk("reset", 0, {cum, sfo, scnt[15:0]});
		@(posedge clk) mp <= 1'b1;
		tsel <= 4'h3;
		for (int r = 1; r < 4; r++) nak(r[4:0]);
		rd(4'h3, 3'h0);
		chk("out_group", 12'h037, cum);
		chk("nak_flags", 3'h7, {fr, fd, fh});
		for (int g = 1; g < 7; g++) repeat (g) evt(g[2:0]);
		for (int g = 1; g < 7; g++) begin
			rd(4'h3, g[2:0]);
			chk("group", {g[7:0], 4'h0}, cum);
		end
		repeat (250) evt(3'h6);
		rd(4'h3, 3'h6);
		chk("cum_sat", 12'hff0, cum);
		rd(4'h5, 3'h6);
		chk("other_trib", 0, cum);
		@(posedge clk) bkg <= 3'h7;
		repeat (2) @(posedge clk);
		bkg <= 3'h1;
		repeat (65535) @(posedge clk);
		bkg <= 3'h0;
		rd(4'h3, 3'h0);
		chk("bkg_tx", 16'hffff, btx);
		chk("bkg_rx_sel", 32'h00020002, {brx, bsel});
		@(posedge clk) tclr <= 1'b1;
		@(posedge clk) tclr <= 1'b0;
		rd(4'h3, 3'h0);
		chk("trib_clr", 0, {cum, btx, fh});
		@(posedge clk) tsel <= 4'h5;
		evt(3'h1);
		rd(4'h5, 3'h1);
		chk("trib5", 12'h010, cum);
		@(posedge clk) est <= 1'b1;
		@(posedge clk) est <= 1'b0;
		rd(4'h5, 3'h1);
		chk("establish", 0, cum);
		@(posedge clk) mp <= 1'b0;
		evt(3'h2);
		rd(4'h0, 3'h2);
		chk("p2p_slot0", 12'h010, cum);
		@(posedge clk) tev <= '{1'b1, 1'b1, 5'h08, 3'h5, 4'h0};
		@(posedge clk) tev.reason <= 5'h10;
		@(posedge clk) tev.valid <= 1'b0;
		rd(4'h0, 3'h5);
		chk("rem_buf", 12'h023, cum);
		@(posedge clk) sinc <= 4'hf;
		sfl <= 4'ha;
		repeat (256) @(posedge clk);
		sinc <= 4'h0;
		sfl <= 4'h0;
		tick(2);
		chk("stn_sat", 32'hffffffff, scnt);
		chk("stn_flags", 4'ha, sfo);
		@(posedge clk) gclr <= 1'b1;
		@(posedge clk) gclr <= 1'b0;
		tick(2);
		chk("stn_clr", 0, scnt);
		chk("stn_flag_clr", 0, sfo);
		summarize();
	end
endmodule
